// ---- design/cplc_ctrl.sv ----
// Purpose: clock, power and loopback control bank behind an AXI4-Lite slave
// Assumes: 32-bit data, one register per aligned word, all logic on aclk
// Notes:   frame sync and symbol tick come from pins and are synchronised
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`include "cplc_defines.svh"

module cplc_ctrl (
  input  wire logic              aclk,            // system clock, 100 MHz
  input  wire logic              aresetn,         // sync reset, active low
  input  wire logic              ce,              // clock enable, freezes state
  input  wire logic [31:0]       s_axi_awaddr,    // write address
  input  wire logic              s_axi_awvalid,   // write address valid
  output logic                   s_axi_awready,   // write address ready
  input  wire logic [31:0]       s_axi_wdata,     // write data
  input  wire logic [3:0]        s_axi_wstrb,     // write byte enables
  input  wire logic              s_axi_wvalid,    // write data valid
  output logic                   s_axi_wready,    // write data ready
  output logic [1:0]             s_axi_bresp,     // write response
  output logic                   s_axi_bvalid,    // write response valid
  input  wire logic              s_axi_bready,    // write response ready
  input  wire logic [31:0]       s_axi_araddr,    // read address
  input  wire logic              s_axi_arvalid,   // read address valid
  output logic                   s_axi_arready,   // read address ready
  output logic [31:0]            s_axi_rdata,     // read data
  output logic [1:0]             s_axi_rresp,     // read response
  output logic                   s_axi_rvalid,    // read data valid
  input  wire logic              s_axi_rready,    // read data ready
  input  wire logic              tx_path_enable,  // transmit setup bit 3
  input  wire logic              rx_path_enable,  // first receive setup bit 3
  input  wire logic              rx_path_active,  // receive path busy
  input  wire logic              frame_sync_any,  // OR of frame sync pins
  input  wire logic              symbol_tick_in,  // symbol clock, async level
  output logic                   tx_clk_gate_en,  // transmit master clock enable
  output logic                   rx_clk_gate_en,  // receive master clock enable
  output logic                   tx_fifo_clk_en,  // transmit FIFO clock enable
  output logic                   rx_port_pwr_en,  // receive data port powered
  output logic                   aux_ramdac_pwr_en, // RAM-driven DAC powered
  output logic                   aux_adc_pwr_en,  // auxiliary ADC powered
  output logic                   sif_pwr_en,      // serial interface powered
  output logic                   analog_bias_en,  // analogue bias chain on
  output logic                   fast_pins_en,    // fast digital output edges
  output logic [3:0]             aux_dac_pwr_en,  // DAC4..DAC1 power up
  output logic                   phase_step_pulse, // one phase shift request
  output logic                   phase_step_adv,  // 1 advance, 0 retard
  output logic [2:0]             phase_step_eighths, // shift in eighths
  output logic                   rx_filter_bypass, // receive passive filter bypass
  output logic                   tx_filter_bypass, // transmit passive filter bypass
  output logic                   codec_iir_bypass, // IIR off, 32 kHz, 16-bit data
  output logic                   codec_analog_loop, // codec DAC to codec ADC
  output logic                   analog_loop,     // transmit DAC to receive ADC
  output logic                   rx_access_wr_en, // receive access point writes
  output logic                   tx_access_wr_en, // transmit access point writes
  output logic                   digital_loop     // tx operator to rx port
);
  import cplc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  cplc_state_t s_reg;
  cplc_state_t s_next;

  logic               aw_take;
  logic               w_take;
  logic               ar_take;
  logic [9:0]         wa;
  logic [31:0]        wd;
  logic [3:0]         ws;
  logic               do_write;
  logic               wr_hit;
  logic [9:0]         ra;
  logic               sym_edge;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  assign s_axi_awready = ce && (s_reg.wr_state == CPLC_WR_IDLE) && !s_reg.aw_held;
  assign s_axi_wready  = ce && (s_reg.wr_state == CPLC_WR_IDLE) && !s_reg.w_held;
  // a read answer must drain before the next address is taken
  assign s_axi_arready = ce && !s_reg.rvalid;

  assign wa = s_reg.aw_held ? s_reg.aw_addr : s_axi_awaddr[`CPLC_ADDR_W-1:0];
  assign wd = s_reg.w_held ? s_reg.w_data : s_axi_wdata;
  assign ws = s_reg.w_held ? s_reg.w_strb : s_axi_wstrb;
  assign do_write = (s_reg.wr_state == CPLC_WR_IDLE) && (s_reg.aw_held || aw_take) &&
                    (s_reg.w_held || w_take);
  assign ra = s_axi_araddr[`CPLC_ADDR_W-1:0];
  assign wr_hit = (wa == `CPLC_ADDR_PHASE) || (wa == `CPLC_ADDR_CLKSTOP) ||
                  (wa == `CPLC_ADDR_POWER) || (wa == `CPLC_ADDR_LOOPBACK);
  assign sym_edge = s_reg.sym_sync && !s_reg.sym_prev;

  always_comb begin
    s_next = s_reg;
    s_next.phase_strobe = 1'b0;
    // ----- write channel -----
    unique case (s_reg.wr_state)
      CPLC_WR_IDLE: begin
        if (aw_take) begin
          s_next.aw_held = 1'b1;
          s_next.aw_addr = s_axi_awaddr[`CPLC_ADDR_W-1:0];
        end
        if (w_take) begin
          s_next.w_held = 1'b1;
          s_next.w_data = s_axi_wdata;
          s_next.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
          s_next.aw_held  = 1'b0;
          s_next.w_held   = 1'b0;
          s_next.wr_state = CPLC_WR_RESP;
          s_next.bvalid   = 1'b1;
          s_next.bresp    = wr_hit ? `CPLC_RESP_OKAY : `CPLC_RESP_SLVERR;
          if (ws[0]) begin
            unique case (wa)
              `CPLC_ADDR_PHASE: begin
                s_next.phase        = wd[7:0] & `CPLC_MASK_PHASE;
                s_next.phase_code   = wd[`CPLC_PHASE_W-1:0];
                s_next.phase_strobe = 1'b1;
              end
              `CPLC_ADDR_CLKSTOP:  s_next.clkstop  = wd[7:0] & `CPLC_MASK_CLKSTOP;
              `CPLC_ADDR_POWER:    s_next.power    = wd[7:0] & `CPLC_MASK_POWER;
              `CPLC_ADDR_LOOPBACK: s_next.loopback = wd[7:0] & `CPLC_MASK_LOOPBACK;
              default: s_next.phase_strobe = 1'b0;
            endcase
          end
        end
      end
      CPLC_WR_RESP: begin
        if (s_axi_bready) begin
          s_next.bvalid   = 1'b0;
          s_next.wr_state = CPLC_WR_IDLE;
        end
      end
      default: s_next.wr_state = CPLC_WR_IDLE;
    endcase
    // ----- read channel, side-effect free -----
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (ar_take) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = `CPLC_RESP_OKAY;
      s_next.rdata  = 32'h0000_0000;
      unique case (ra)
        `CPLC_ADDR_PHASE:    s_next.rdata[7:0] = s_reg.phase;
        `CPLC_ADDR_CLKSTOP:  s_next.rdata[7:0] = s_reg.clkstop;
        `CPLC_ADDR_POWER:    s_next.rdata[7:0] = s_reg.power;
        `CPLC_ADDR_LOOPBACK: s_next.rdata[7:0] = s_reg.loopback;
        default:             s_next.rresp      = `CPLC_RESP_SLVERR;
      endcase
    end
    // ----- serial interface auto clock stop -----
    s_next.fs_meta  = frame_sync_any;
    s_next.fs_sync  = s_reg.fs_meta;
    s_next.sym_meta = symbol_tick_in;
    s_next.sym_sync = s_reg.sym_meta;
    s_next.sym_prev = s_reg.sym_sync;
    if (s_reg.fs_sync || !s_reg.clkstop[`CPLC_CS_SIF_AUTO]) begin
      s_next.idle_syms = 3'h0;
      s_next.sif_down  = 1'b0;
    end else if (sym_edge && !s_reg.sif_down) begin
      // partial first period makes the stop land after 6 to 7 symbols
      if (s_reg.idle_syms == `CPLC_SIF_IDLE_SYMS) begin
        s_next.sif_down = 1'b1;
      end else begin
        s_next.idle_syms = s_reg.idle_syms + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg          <= '0;
      s_reg.wr_state <= CPLC_WR_IDLE;
      s_reg.phase    <= `CPLC_RST_BYTE;
      s_reg.clkstop  <= `CPLC_RST_BYTE;
      s_reg.power    <= `CPLC_RST_BYTE;
      s_reg.loopback <= `CPLC_RST_BYTE;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // phase step decode
  // ----------------------------------------
  cplc_phase_step u_phase (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ce           (ce),
    .strobe       (s_reg.phase_strobe),
    .code         (s_reg.phase_code),
    .step_pulse   (phase_step_pulse),
    .step_adv     (phase_step_adv),
    .step_eighths (phase_step_eighths)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp  = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata  = s_reg.rdata;
  assign s_axi_rresp  = s_reg.rresp;

  // gating without the auto bit leaves the path clock running
  assign tx_clk_gate_en = !s_reg.clkstop[`CPLC_CS_TX_AUTO] || tx_path_enable;
  assign rx_clk_gate_en = !s_reg.clkstop[`CPLC_CS_RX_AUTO] || rx_path_enable;
  assign tx_fifo_clk_en = !s_reg.clkstop[`CPLC_CS_FIFO_STOP];
  assign rx_port_pwr_en = !s_reg.clkstop[`CPLC_CS_RXPORT_STOP] || rx_path_active;
  assign aux_ramdac_pwr_en = !s_reg.clkstop[`CPLC_CS_AUX_STOP];
  assign aux_adc_pwr_en    = !s_reg.clkstop[`CPLC_CS_AUX_STOP];
  assign sif_pwr_en     = !s_reg.sif_down;
  assign analog_bias_en = s_reg.power[`CPLC_PW_BIAS];
  assign fast_pins_en   = s_reg.power[`CPLC_PW_FAST_PINS];
  assign aux_dac_pwr_en = s_reg.power[3:0];
  assign rx_filter_bypass  = s_reg.loopback[`CPLC_LB_RXF_BYP];
  assign tx_filter_bypass  = s_reg.loopback[`CPLC_LB_TXF_BYP];
  assign codec_iir_bypass  = s_reg.loopback[`CPLC_LB_IIR_BYP];
  assign codec_analog_loop = s_reg.loopback[`CPLC_LB_CODEC_LOOP];
  assign analog_loop       = s_reg.loopback[`CPLC_LB_ANA_LOOP];
  assign rx_access_wr_en   = s_reg.loopback[`CPLC_LB_RX_ACCESS];
  assign tx_access_wr_en   = s_reg.loopback[`CPLC_LB_TX_ACCESS];
  assign digital_loop      = s_reg.loopback[`CPLC_LB_DIG_LOOP];
endmodule

// ---- design/cplc_defines.svh ----
// Purpose: constants for the clock, power and loopback control bank
// Assumes: byte addresses are four times the register index
// Notes:   definitions only
`ifndef CPLC_DEFINES_SVH
`define CPLC_DEFINES_SVH

// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define CPLC_IDX_PHASE       8'h10
`define CPLC_IDX_CLKSTOP     8'h11
`define CPLC_IDX_POWER       8'h12
`define CPLC_IDX_LOOPBACK    8'h13
`define CPLC_ADDR_PHASE      10'h040
`define CPLC_ADDR_CLKSTOP    10'h044
`define CPLC_ADDR_POWER      10'h048
`define CPLC_ADDR_LOOPBACK   10'h04C
`define CPLC_ADDR_W          10

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define CPLC_RST_BYTE        8'h00
`define CPLC_MASK_PHASE      8'h07
`define CPLC_MASK_CLKSTOP    8'h3F
`define CPLC_MASK_POWER      8'h3F
`define CPLC_MASK_LOOPBACK   8'hFF

// ----------------------------------------
// field positions
// ----------------------------------------
`define CPLC_CS_TX_AUTO      5
`define CPLC_CS_FIFO_STOP    4
`define CPLC_CS_RXPORT_STOP  3
`define CPLC_CS_AUX_STOP     2
`define CPLC_CS_SIF_AUTO     1
`define CPLC_CS_RX_AUTO      0
`define CPLC_PW_FAST_PINS    5
`define CPLC_PW_BIAS         4
`define CPLC_LB_RXF_BYP      7
`define CPLC_LB_TXF_BYP      6
`define CPLC_LB_IIR_BYP      5
`define CPLC_LB_CODEC_LOOP   4
`define CPLC_LB_ANA_LOOP     3
`define CPLC_LB_RX_ACCESS    2
`define CPLC_LB_TX_ACCESS    1
`define CPLC_LB_DIG_LOOP     0

// ----------------------------------------
// timing, widths and response codes
// ----------------------------------------
`define CPLC_SIF_IDLE_SYMS   3'h6
`define CPLC_SIF_IDLE_W      3
`define CPLC_PHASE_W         3
`define CPLC_RESP_OKAY       2'h0
`define CPLC_RESP_SLVERR     2'h2

`endif

// ---- design/cplc_phase_step.sv ----
// Purpose: decodes a phase step code into direction and eighths of a symbol
// Assumes: code is held stable while strobe is high
// Notes:   registered outputs, one cycle after the strobe
`timescale 1ns/1ns
`include "cplc_defines.svh"
module cplc_phase_step (
  input  wire logic                       aclk,       // system clock
  input  wire logic                       aresetn,    // sync reset, active low
  input  wire logic                       ce,         // clock enable
  input  wire logic                       strobe,     // write event
  input  wire logic [`CPLC_PHASE_W-1:0]   code,       // written step code
  output logic                            step_pulse, // one shift request
  output logic                            step_adv,   // 1 advance, 0 retard
  output logic [2:0]                      step_eighths // amount in eighths
);
  import cplc_pkg::*;

  cplc_phase_step_t kind;
  logic             adv_next;
  logic [2:0]       amt_next;

  always_comb begin
    kind     = cplc_phase_step_t'({1'b0, code});
    adv_next = 1'b0;
    amt_next = 3'h0;
    unique case (kind)
      CPLC_PH_HOLD:    amt_next = 3'h0;
      CPLC_PH_RET_1_8: amt_next = 3'h1;
      CPLC_PH_RET_1_4: amt_next = 3'h2;
      CPLC_PH_RET_3_8: amt_next = 3'h3;
      CPLC_PH_ADV_1_2: begin
        adv_next = 1'b1;
        amt_next = 3'h4;
      end
      CPLC_PH_ADV_3_8: begin
        adv_next = 1'b1;
        amt_next = 3'h3;
      end
      CPLC_PH_ADV_1_4: begin
        adv_next = 1'b1;
        amt_next = 3'h2;
      end
      CPLC_PH_ADV_1_8: begin
        adv_next = 1'b1;
        amt_next = 3'h1;
      end
      default: amt_next = 3'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_pulse   <= 1'b0;
      step_adv     <= 1'b0;
      step_eighths <= 3'h0;
    end else if (ce) begin
      step_pulse   <= strobe;
      if (strobe) begin
        step_adv     <= adv_next;
        step_eighths <= amt_next;
      end
    end
  end
endmodule

// ---- design/cplc_pkg.sv ----
// Purpose: types for the clock, power and loopback control bank
// Assumes: used with cplc_defines.svh
// Notes:   types only
package cplc_pkg;

  typedef enum logic [1:0] {
    CPLC_WR_IDLE,
    CPLC_WR_RESP
  } cplc_wr_state_t;

  typedef enum logic [3:0] {
    CPLC_PH_HOLD,
    CPLC_PH_RET_1_8,
    CPLC_PH_RET_1_4,
    CPLC_PH_RET_3_8,
    CPLC_PH_ADV_1_2,
    CPLC_PH_ADV_3_8,
    CPLC_PH_ADV_1_4,
    CPLC_PH_ADV_1_8
  } cplc_phase_step_t;

  typedef struct packed {
    cplc_wr_state_t wr_state;
    logic           aw_held;
    logic           w_held;
    logic [9:0]     aw_addr;
    logic [31:0]    w_data;
    logic [3:0]     w_strb;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
    logic [7:0]     phase;
    logic [7:0]     clkstop;
    logic [7:0]     power;
    logic [7:0]     loopback;
    logic           phase_strobe;
    logic [2:0]     phase_code;
    logic           fs_meta;
    logic           fs_sync;
    logic           sym_meta;
    logic           sym_sync;
    logic           sym_prev;
    logic [2:0]     idle_syms;
    logic           sif_down;
  } cplc_state_t;

endpackage

// ---- tb/clock_power_loopback_ctrl_bench.sv ----
// Purpose: self-checking bench of the control bank
// Assumes: host model owns the register bus, bench owns the side inputs
// Notes:   monitors compare on the falling edge against queued notes
`timescale 1ns/1ns
`include "cplc_defines.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module clock_power_loopback_ctrl_bench;
  import cplc_pkg::*;
  localparam logic [31:0] A_PH = 32'(`CPLC_ADDR_PHASE), A_CS = 32'(`CPLC_ADDR_CLKSTOP);
  localparam logic [31:0] A_PW = 32'(`CPLC_ADDR_POWER), A_LB = 32'(`CPLC_ADDR_LOOPBACK), A_NONE = 32'h50;
  localparam logic [1:0]  OK = `CPLC_RESP_OKAY, ERR = `CPLC_RESP_SLVERR;
  logic        aclk = 1'b0, aresetn, ce, tx_path_enable, rx_path_enable, rx_path_active, frame_sync_any;
  logic        symbol_tick_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, aux_dac_pwr_en, e4;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        tx_clk_gate_en, rx_clk_gate_en, tx_fifo_clk_en, rx_port_pwr_en, aux_ramdac_pwr_en;
  logic        aux_adc_pwr_en, sif_pwr_en, analog_bias_en, fast_pins_en, phase_step_pulse, phase_step_adv;
  logic [2:0]  phase_step_eighths;
  logic        rx_filter_bypass, tx_filter_bypass, codec_iir_bypass, codec_analog_loop, analog_loop;
  logic        rx_access_wr_en, tx_access_wr_en, digital_loop;
  logic [7:0]  v, p, l;
  logic [31:0] e32, exp_rd[$];
  logic [3:0]  exp_ph[$];
  logic [2:0]  ph_tab[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h3, 3'h2, 3'h1};
  int          n_mismatch = 0, cmp_count = 0;

  cplc_ctrl i_dut (.*);
  cplc_host i_host (.*);

  always #5 aclk = ~aclk;

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_host.wr(a, {24'h0, d}, r);
    `CHK("bresp", er, r)
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    exp_rd.push_back({24'h0, e});
    i_host.rd(a, d, r);
    `CHK("rresp", er, r)
  endtask

  task automatic sym_period;
    @(posedge aclk);
    symbol_tick_in <= 1'b1;
    repeat (4) @(posedge aclk);
    symbol_tick_in <= 1'b0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask

  // ----------------------------------------
  // monitors
  // ----------------------------------------
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e32 = (exp_rd.size() > 0) ? exp_rd.pop_front() : 32'hFFFF_FFFF;
      `CHK("read data", e32, s_axi_rdata)
    end
    if (phase_step_pulse) begin
      e4 = (exp_ph.size() > 0) ? exp_ph.pop_front() : 4'hF;
      `CHK("phase step", e4, {phase_step_adv & (phase_step_eighths != 3'h0), phase_step_eighths})
    end
  end

  initial begin
    #500000;
    n_mismatch++;
    print_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {aresetn, tx_path_enable, rx_path_enable, rx_path_active, frame_sync_any, symbol_tick_in} = '0;
    ce = 1'b1;
    void'($urandom(84));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) rd(A_PH + 32'(4 * i), 8'h00, OK);
    rd(A_NONE, 8'h00, ERR);
    @(negedge aclk);
    `CHK("reset outs", 9'h1E0, {tx_fifo_clk_en, aux_ramdac_pwr_en, aux_adc_pwr_en, sif_pwr_en, analog_bias_en, aux_dac_pwr_en})
    for (int c = 0; c < 8; c++) begin
      exp_ph.push_back({c >= 4, ph_tab[c]});
      wr(A_PH, 8'(c), OK);
      rd(A_PH, 8'(c), OK);
    end
    exp_ph.push_back(4'hB);
    exp_ph.push_back(4'h2);
    wr(A_PH, 8'h05, OK);
    wr(A_PH, 8'h02, OK);
    rd(A_PH, 8'h02, OK);
    repeat (16) begin
      v = 8'($urandom) & 8'h3D;
      wr(A_CS, v, OK);
      {tx_path_enable, rx_path_enable, rx_path_active} <= 3'($urandom);
      @(negedge aclk);
      `CHK("tx gate", !v[5] | tx_path_enable, tx_clk_gate_en)
      `CHK("fifo clock", !v[4], tx_fifo_clk_en)
      `CHK("rx port", !v[3] | rx_path_active, rx_port_pwr_en)
      `CHK("aux power", {!v[2], !v[2]}, {aux_ramdac_pwr_en, aux_adc_pwr_en})
      `CHK("rx gate", !v[0] | rx_path_enable, rx_clk_gate_en)
    end
    repeat (8) begin
      p = 8'($urandom) & 8'h3F;
      l = 8'($urandom);
      wr(A_PW, p, OK);
      wr(A_LB, l, OK);
      @(negedge aclk);
      `CHK("power outs", p[5:0], {fast_pins_en, analog_bias_en, aux_dac_pwr_en})
      `CHK("loop outs", l, {rx_filter_bypass, tx_filter_bypass, codec_iir_bypass, codec_analog_loop, analog_loop, rx_access_wr_en, tx_access_wr_en, digital_loop})
    end
    wr(A_NONE, 8'hA5, ERR);
    rd(A_LB, l, OK);
    rd(A_PW, p, OK);
    wr(A_CS, 8'h02, OK);
    for (int k = 1; k <= 7; k++) begin
      sym_period();
      `CHK("serial power", k < 7, sif_pwr_en)
    end
    @(posedge aclk);
    frame_sync_any <= 1'b1;
    repeat (6) @(posedge aclk);
    frame_sync_any <= 1'b0;
    @(negedge aclk);
    `CHK("serial restart", 1'b1, sif_pwr_en)
    `CHK("phase steps left", 0, exp_ph.size())
    print_verdict();
  end
endmodule

// ---- tb/cplc_ctrl_assertions.sv ----
// Purpose: port-level checks of the control bank
// Assumes: address and data halves of a phase write are taken together
// Notes:   bound to every cplc_ctrl instance
`timescale 1ns/1ns
`include "cplc_defines.svh"
module cplc_ctrl_chk (
  input wire logic        aclk,              // clock
  input wire logic        aresetn,           // reset, active low
  input wire logic [31:0] s_axi_awaddr,      // watched
  input wire logic        s_axi_awvalid,     // watched
  input wire logic        s_axi_awready,     // watched
  input wire logic [31:0] s_axi_wdata,       // watched
  input wire logic        s_axi_wvalid,      // watched
  input wire logic        s_axi_wready,      // watched
  input wire logic        s_axi_bvalid,      // watched
  input wire logic        s_axi_arvalid,     // watched
  input wire logic        s_axi_arready,     // watched
  input wire logic        s_axi_rvalid,      // watched
  input wire logic        tx_path_enable,    // watched
  input wire logic        rx_path_enable,    // watched
  input wire logic        rx_path_active,    // watched
  input wire logic        frame_sync_any,    // watched
  input wire logic        tx_clk_gate_en,    // watched
  input wire logic        rx_clk_gate_en,    // watched
  input wire logic        tx_fifo_clk_en,    // watched
  input wire logic        rx_port_pwr_en,    // watched
  input wire logic        aux_ramdac_pwr_en, // watched
  input wire logic        aux_adc_pwr_en,    // watched
  input wire logic        sif_pwr_en,        // watched
  input wire logic        analog_bias_en,    // watched
  input wire logic [3:0]  aux_dac_pwr_en,    // watched
  input wire logic        phase_step_pulse,  // watched
  input wire logic        phase_step_adv,    // watched
  input wire logic [2:0]  phase_step_eighths, // watched
  input wire logic        digital_loop       // watched
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire logic [8:0] reg_outs = {tx_fifo_clk_en, aux_adc_pwr_en, analog_bias_en, aux_dac_pwr_en, digital_loop, sif_pwr_en};
  wire logic       wr_both  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  function automatic logic [2:0] eighths(logic [2:0] c);
    return c[2] ? 3'(4'h8 - {1'b0, c}) : c;
  endfunction

  sequence s_phase_wr;
    wr_both && s_axi_awaddr[9:0] == `CPLC_ADDR_PHASE;
  endsequence
  sequence s_phase_out;
    ##2 phase_step_pulse && phase_step_eighths == eighths($past(s_axi_wdata[2:0], 2))
      && (phase_step_eighths == 3'h0 || phase_step_adv == $past(s_axi_wdata[2], 2));
  endsequence

  property p_phase_step;  s_phase_wr |-> s_phase_out; endproperty
  property p_read_quiet;
    s_axi_arvalid && s_axi_arready && !(s_axi_awvalid && s_axi_awready) && !(s_axi_wvalid && s_axi_wready)
      |-> ##2 !phase_step_pulse;
  endproperty
  property p_rd_answer;   s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_wr_answer;   wr_both |=> s_axi_bvalid; endproperty
  property p_reg_change;  $past(aresetn) && $changed(reg_outs[8:1]) |-> $rose(s_axi_bvalid); endproperty
  property p_tx_gate;     tx_path_enable |-> tx_clk_gate_en; endproperty
  property p_rx_gate;     rx_path_enable |-> rx_clk_gate_en; endproperty
  property p_rx_port;     rx_path_active |-> rx_port_pwr_en; endproperty
  property p_aux_pair;    aux_ramdac_pwr_en == aux_adc_pwr_en; endproperty
  property p_sif_restart; frame_sync_any [*3] |-> ##[0:4] sif_pwr_en; endproperty

  a_phase_step:  assert property (p_phase_step)  else $error("phase step missing or wrong");
  a_read_quiet:  assert property (p_read_quiet)  else $error("read caused a phase step");
  a_rd_answer:   assert property (p_rd_answer)   else $error("read not answered");
  a_wr_answer:   assert property (p_wr_answer)   else $error("write not answered");
  a_reg_change:  assert property (p_reg_change)  else $error("control output moved without write");
  a_tx_gate:     assert property (p_tx_gate)     else $error("tx clock gated while path enabled");
  a_rx_gate:     assert property (p_rx_gate)     else $error("rx clock gated while path enabled");
  a_rx_port:     assert property (p_rx_port)     else $error("rx port off while path active");
  a_aux_pair:    assert property (p_aux_pair)    else $error("aux dac and adc power differ");
  a_sif_restart: assert property (p_sif_restart) else $error("serial interface not restarted");
endmodule

bind cplc_ctrl cplc_ctrl_chk i_chk (.*);

// ---- tb/cplc_host.sv ----
// Purpose: host model driving the control bank over AXI4-Lite
// Assumes: one write and one read at a time, handshakes taken at rising edges
// Notes:   readies and answers are looked at on the falling edge, settled by then
`timescale 1ns/1ns
module cplc_host (
  input  wire logic        aclk,          // system clock
  output logic [31:0]      s_axi_awaddr,  // write address
  output logic             s_axi_awvalid, // write address valid
  input  wire logic        s_axi_awready, // write address ready
  output logic [31:0]      s_axi_wdata,   // write data
  output logic [3:0]       s_axi_wstrb,   // byte enables
  output logic             s_axi_wvalid,  // write data valid
  input  wire logic        s_axi_wready,  // write data ready
  input  wire logic [1:0]  s_axi_bresp,   // write response
  input  wire logic        s_axi_bvalid,  // write response valid
  output logic             s_axi_bready,  // write response ready
  output logic [31:0]      s_axi_araddr,  // read address
  output logic             s_axi_arvalid, // read address valid
  input  wire logic        s_axi_arready, // read address ready
  input  wire logic [31:0] s_axi_rdata,   // read data
  input  wire logic [1:0]  s_axi_rresp,   // read response
  input  wire logic        s_axi_rvalid,  // read data valid
  output logic             s_axi_rready   // read data ready
);
  // no fifo traffic and no serial clock setup come from this host
  // bias-dependent sections sit in other blocks and are never enabled here
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha;
    logic hw;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    @(negedge aclk);
    while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) begin
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      @(negedge aclk);
    end
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    @(negedge aclk);
    while (s_axi_arvalid || !s_axi_rvalid) begin
      h = s_axi_arvalid && s_axi_arready;
      @(posedge aclk);
      if (h) s_axi_arvalid <= 1'b0;
      @(negedge aclk);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
endmodule
